// ===== core/lam_params.svh
// constants for the link alarm maintenance block
// assumes one recovered-byte clock and control words delivered in order
`ifndef LAM_PARAMS_SVH
`define LAM_PARAMS_SVH

// control words per hyperframe, last index
`define LAM_LAST_INDEX 8'hFF
// control word index that carries the alarm byte (sub-index 0)
`define LAM_ALARM_INDEX 8'h82
// bit positions inside the alarm byte
`define LAM_BIT_REMOTE 1
`define LAM_BIT_SAP 2
`define LAM_BIT_LOS 3
`define LAM_BIT_LOF 4
// violations per hyperframe that raise loss of signal
`define LAM_LOS_VIOL_LIMIT 5'h10
// alignment: good hyperframe starts needed to lock
`define LAM_ACQ_STATES 2'h2
// alignment: missed hyperframe starts that drop lock
`define LAM_SYNC_STATES 2'h3
// descrambler check length in bits and in checked bytes
`define LAM_DESCR_BITS 32
`define LAM_DESCR_BYTES 3'h4
// protocol version that enables the scrambler-aware procedure
`define LAM_PROTO_SCRAMBLED 4'h2
// filter indices: near end 0..2, far end 3..6
`define LAM_F_NEAR_LOS 0
`define LAM_F_NEAR_LOF 1
`define LAM_F_NEAR_RAI 2
`define LAM_F_FAR_LOS 3
`define LAM_F_FAR_LOF 4
`define LAM_F_FAR_RAI 5
`define LAM_F_FAR_SAP 6
`define LAM_F_COUNT 7

`endif

// ===== core/lam_pkg.sv
// types shared by the link alarm maintenance block
// assumes lam_params.svh for all numeric constants
package lam_pkg;

  // one received control word with its line-code status
  typedef struct packed {
    logic valid;
    logic comma;
    logic violation;
    logic descr_valid;
    logic descr_match;
    logic [7:0] data;
  } lam_rx_word_t;

  // the four in-band alarms, in byte order b4..b1
  typedef struct packed {
    logic frame_loss_alarm;
    logic signal_loss_alarm;
    logic access_point_defect_alarm;
    logic remote_alarm;
  } lam_alarm_t;

  // filter durations in clock cycles
  typedef struct packed {
    logic [15:0] near_set;
    logic [15:0] near_clear;
    logic [15:0] far_set;
    logic [15:0] far_clear;
  } lam_filter_cfg_t;

  // hyperframe alignment states
  typedef enum logic [1:0] {
    align_lost,
    alignment_acquire_state,
    alignment_locked_state
  } lam_align_t;

endpackage : lam_pkg

// ===== core/lam_filter.sv
// persistence filter turning a raw alarm into a failure
// assumes durations are stable while the alarm is being filtered
module lam_filter
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw alarm and filter durations in cycles
  input wire logic raw,
  input wire logic [15:0] set_count,
  input wire logic [15:0] clear_count,
  // filtered failure
  output logic failure
);

  logic [15:0] persist;
  logic [15:0] limit;

  // duration that applies to the pending change
  assign limit = failure ? clear_count : set_count;

  // count cycles that the raw level differs from the failure
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      persist <= 16'h0000;
    end
    else if (raw == failure || persist >= limit)
    begin
      persist <= 16'h0000;
    end
    else
    begin
      persist <= persist + 16'h0001;
    end
  end

  // change the failure once the difference has persisted
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      failure <= 1'b0;
    end
    else if (raw != failure && persist >= limit)
    begin
      failure <= raw;
    end
  end

endmodule // lam_filter

// ===== core/lam_top.sv
// layer 1 link alarm detection, signalling and local actions
// assumes one control word per basic frame, synchronous to ref_clk
`include "lam_params.svh"

module lam_top
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // received control words
  input lam_pkg::lam_rx_word_t rx_word,
  // receiver status and role
  input wire logic optical_power_low,
  input wire logic transceiver_error,
  input wire logic startup_at_c,
  input wire logic radio_unit,
  input wire logic [3:0] local_max_version,
  input wire logic [3:0] far_version,
  // application configuration
  input wire logic access_point_defect_request,
  input lam_pkg::lam_filter_cfg_t filter_cfg,
  // transmitted alarm byte for word 130.0
  output logic [7:0] tx_alarm_byte,
  // near-end raw alarms and alignment
  output lam_pkg::lam_alarm_t near_alarms,
  output logic hyperframe_number_locked,
  // received far-end alarms
  output lam_pkg::lam_alarm_t far_alarms,
  // local actions
  output logic resync_to_state_b,
  output logic emission_block,
  output logic service_withdraw,
  output logic frame_numbers_invalid
);

  lam_pkg::lam_align_t align_state;
  logic [7:0] word_index;
  logic [1:0] good_count;
  logic [1:0] miss_count;
  logic [2:0] descr_count;
  logic descr_ok;
  logic scrambler_mode;
  logic at_expected;
  logic hf_end;
  logic [4:0] viol_count;
  logic los_raw;
  logic lof_raw;
  logic rai_raw;
  logic [4:0] next_viol_count;
  logic [`LAM_F_COUNT-1:0] filter_raw;
  logic [`LAM_F_COUNT-1:0] filter_fail;
  logic near_state_b;
  logic far_state_b;

  // word position of the current control word in the hyperframe
  assign at_expected = rx_word.valid && word_index == 8'h00;
  assign hf_end = rx_word.valid && word_index == `LAM_LAST_INDEX;

  // track control word index, realigned by a comma while alignment is lost
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word_index <= 8'h00;
    end
    else if (rx_word.valid)
    begin
      if (align_state == lam_pkg::align_lost && rx_word.comma)
      begin
        word_index <= 8'h01;
      end
      else
      begin
        word_index <= word_index + 8'h01;
      end
    end
  end

  assign scrambler_mode = local_max_version == `LAM_PROTO_SCRAMBLED &&
                          far_version != 4'h1;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      descr_count <= 3'h0;
    end
    else if (align_state == lam_pkg::align_lost)
    begin
      descr_count <= 3'h0;
    end
    else if (rx_word.valid && rx_word.descr_valid)
    begin
      if (!rx_word.descr_match)
      begin
        descr_count <= 3'h0;
      end
      else if (descr_count != `LAM_DESCR_BYTES)
      begin
        descr_count <= descr_count + 3'h1;
      end
    end
  end

  // check passed once all bits matched
  assign descr_ok = !scrambler_mode || descr_count == `LAM_DESCR_BYTES;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      align_state <= lam_pkg::align_lost;
      good_count <= 2'h0;
      miss_count <= 2'h0;
    end
    else if (rx_word.valid)
    begin
      case (align_state)
        lam_pkg::align_lost:
        begin
          if (rx_word.comma)
          begin
            align_state <= lam_pkg::alignment_acquire_state;
            good_count <= 2'h1;
          end
          miss_count <= 2'h0;
        end
        lam_pkg::alignment_acquire_state:
        begin
          if (at_expected && !rx_word.comma)
          begin
            align_state <= lam_pkg::align_lost;
            good_count <= 2'h0;
          end
          else if (good_count >= `LAM_ACQ_STATES && descr_ok)
          begin
            align_state <= lam_pkg::alignment_locked_state;
          end
          else if (at_expected && good_count < `LAM_ACQ_STATES)
          begin
            good_count <= good_count + 2'h1;
          end
        end
        lam_pkg::alignment_locked_state:
        begin
          if (at_expected && rx_word.comma)
          begin
            miss_count <= 2'h0;
          end
          else if (at_expected && miss_count + 2'h1 == `LAM_SYNC_STATES)
          begin
            align_state <= lam_pkg::align_lost;
            miss_count <= 2'h0;
            good_count <= 2'h0;
          end
          else if (at_expected)
          begin
            miss_count <= miss_count + 2'h1;
          end
        end
        default:
        begin
          align_state <= lam_pkg::align_lost;
        end
      endcase
    end
  end

  assign lof_raw = align_state != lam_pkg::alignment_locked_state;

  // violation count including this word, restarted per hyperframe
  always_comb
  begin
    next_viol_count = viol_count;
    if (rx_word.valid && rx_word.violation &&
        viol_count != `LAM_LOS_VIOL_LIMIT)
    begin
      next_viol_count = viol_count + 5'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      viol_count <= 5'h00;
    end
    else if (hf_end)
    begin
      viol_count <= 5'h00;
    end
    else
    begin
      viol_count <= next_viol_count;
    end
  end

  // loss of signal from violations or optical power
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      los_raw <= 1'b0;
    end
    else if (optical_power_low)
    begin
      los_raw <= 1'b1;
    end
    else if (hf_end && next_viol_count >= `LAM_LOS_VIOL_LIMIT)
    begin
      los_raw <= 1'b1;
    end
    else if (hf_end && next_viol_count == 5'h00)
    begin
      los_raw <= 1'b0;
    end
  end

  // remote alarm covers all transceiver errors
  assign rai_raw = los_raw || lof_raw || transceiver_error;

  // decode far alarms only from state C onward
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      far_alarms <= '0;
    end
    else if (!startup_at_c)
    begin
      far_alarms <= '0;
    end
    // pick the alarm bits out of word 130.0
    else if (rx_word.valid && word_index == `LAM_ALARM_INDEX)
    begin
      far_alarms.remote_alarm <= rx_word.data[`LAM_BIT_REMOTE];
      far_alarms.access_point_defect_alarm <= rx_word.data[`LAM_BIT_SAP];
      far_alarms.signal_loss_alarm <= rx_word.data[`LAM_BIT_LOS];
      far_alarms.frame_loss_alarm <= rx_word.data[`LAM_BIT_LOF];
    end
  end

  // in-band bits follow the raw alarms one cycle later, unfiltered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_alarm_byte <= 8'h00;
      near_alarms <= '0;
    end
    else
    begin
      tx_alarm_byte <= 8'h00;
      tx_alarm_byte[`LAM_BIT_REMOTE] <= rai_raw;
      tx_alarm_byte[`LAM_BIT_SAP] <= access_point_defect_request;
      tx_alarm_byte[`LAM_BIT_LOS] <= los_raw;
      tx_alarm_byte[`LAM_BIT_LOF] <= lof_raw;
      near_alarms.remote_alarm <= rai_raw;
      near_alarms.access_point_defect_alarm <= access_point_defect_request;
      near_alarms.signal_loss_alarm <= los_raw;
      near_alarms.frame_loss_alarm <= lof_raw;
    end
  end

  // raw inputs of the persistence filters
  assign filter_raw[`LAM_F_NEAR_LOS] = los_raw;
  assign filter_raw[`LAM_F_NEAR_LOF] = lof_raw;
  assign filter_raw[`LAM_F_NEAR_RAI] = rai_raw;
  assign filter_raw[`LAM_F_FAR_LOS] = far_alarms.signal_loss_alarm;
  assign filter_raw[`LAM_F_FAR_LOF] = far_alarms.frame_loss_alarm;
  assign filter_raw[`LAM_F_FAR_RAI] = far_alarms.remote_alarm;
  assign filter_raw[`LAM_F_FAR_SAP] = far_alarms.access_point_defect_alarm;

  // time filters, near and far durations
  for (genvar i = 0; i < `LAM_F_COUNT; i++)
  begin : g_filter
    lam_filter u_filter
    (
      .ref_clk(ref_clk),
      .rst(rst),
      .raw(filter_raw[i]),
      .set_count(i < `LAM_F_FAR_LOS ? filter_cfg.near_set :
                 filter_cfg.far_set),
      .clear_count(i < `LAM_F_FAR_LOS ? filter_cfg.near_clear :
                   filter_cfg.far_clear),
      .failure(filter_fail[i])
    );
  end

  assign near_state_b = filter_fail[`LAM_F_NEAR_LOS] ||
                        filter_fail[`LAM_F_NEAR_LOF];
  // far signal, frame or remote failure
  assign far_state_b = filter_fail[`LAM_F_FAR_LOS] ||
                       filter_fail[`LAM_F_FAR_LOF] ||
                       filter_fail[`LAM_F_FAR_RAI];

  // local actions on filtered failures, frame numbers invalid on raw far alarms
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resync_to_state_b <= 1'b0;
      emission_block <= 1'b0;
      service_withdraw <= 1'b0;
      hyperframe_number_locked <= 1'b0;
      frame_numbers_invalid <= 1'b0;
    end
    else
    begin
      resync_to_state_b <= near_state_b || far_state_b;
      service_withdraw <= filter_fail[`LAM_F_FAR_SAP];
      // radio unit stops emitting as well
      emission_block <= radio_unit && (near_state_b || far_state_b ||
                        filter_fail[`LAM_F_FAR_SAP]);
      hyperframe_number_locked <=
        align_state == lam_pkg::alignment_locked_state;
      frame_numbers_invalid <= !radio_unit && (|far_alarms);
    end
  end

endmodule // lam_top

// ===== tb/lam_peer.sv
// far-end peer model sending one control word per basic frame
// assumes the bench changes its controls early in a hyperframe
`include "lam_params.svh"
module lam_peer
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // controls for the coming words
  input wire logic send,
  input wire logic send_comma,
  input wire logic descr_ok,
  input wire logic [7:0] viol_words,
  input wire logic [7:0] alarm_byte,
  // word stream and its position
  output lam_pkg::lam_rx_word_t rx_word,
  output logic [7:0] idx
);
  // free-running word position, steps with the sampling edge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      idx <= 8'h00;
    end
    else
    begin
      idx <= idx + 8'h01;
    end
  end
  // violations in the last words only
  always_comb
  begin
    rx_word.valid = send;
    rx_word.comma = send_comma && idx == 8'h00;
    rx_word.violation = send && (8'hFF - idx) < viol_words;
    rx_word.descr_valid = send;
    rx_word.descr_match = descr_ok;
    rx_word.data = (idx == `LAM_ALARM_INDEX) ? alarm_byte : ~idx;
  end
endmodule // lam_peer

// ===== tb/lam_top_sva.sv
// assertions on the ports of the link alarm block
// assumes filter durations of at most three cycles
module lam_top_chk
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched inputs
  input wire logic transceiver_error,
  input wire logic startup_at_c,
  input wire logic radio_unit,
  input wire logic access_point_defect_request,
  // watched outputs
  input wire logic [7:0] tx_alarm_byte,
  input lam_pkg::lam_alarm_t near_alarms,
  input lam_pkg::lam_alarm_t far_alarms,
  input wire logic hyperframe_number_locked,
  input wire logic resync_to_state_b,
  input wire logic emission_block,
  input wire logic service_withdraw,
  input wire logic frame_numbers_invalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_spare_low: assert property (tx_alarm_byte[7:5] == 3'h0)
    else $error("spare alarm bits set");
  a_bits_placed: assert property (
    tx_alarm_byte[4:1] == near_alarms)
    else $error("alarm byte differs from near alarms");
  a_defect_follow: assert property (!$past(rst) |->
    near_alarms.access_point_defect_alarm == $past(access_point_defect_request))
    else $error("defect bit does not follow request");
  a_remote_err: assert property (
    !$past(rst) && $past(transceiver_error) |-> near_alarms.remote_alarm)
    else $error("remote alarm missing on error");
  a_far_gated: assert property (
    !startup_at_c [*2] |-> far_alarms == 4'h0)
    else $error("far alarms decoded below state C");
  a_invalid_role: assert property (
    radio_unit [*2] |-> !frame_numbers_invalid)
    else $error("frame numbers flagged in radio unit role");
  a_emit_role: assert property (!radio_unit [*2] |-> !emission_block)
    else $error("emission blocked in controller role");
  a_los_resync: assert property (
    near_alarms.signal_loss_alarm [*8] |-> resync_to_state_b)
    else $error("no resync after signal loss");
  a_far_resync: assert property (
    far_alarms.remote_alarm [*8] |-> resync_to_state_b)
    else $error("no resync after far remote alarm");
  a_sap_withdraw: assert property (
    far_alarms.access_point_defect_alarm [*8] |-> service_withdraw)
    else $error("services kept after far defect");
  a_resync_clear: assert property (
    !(near_alarms[3] | near_alarms[2] | far_alarms[3] | far_alarms[2]
    | far_alarms[0]) [*8] |-> !resync_to_state_b)
    else $error("resync kept without cause");
  a_lock_lof: assert property (
    !$past(rst) && $stable(hyperframe_number_locked)
    |-> near_alarms.frame_loss_alarm == !hyperframe_number_locked)
    else $error("frame loss disagrees with lock");
  // main scenarios reached
  c_los_set: cover property ($rose(near_alarms.signal_loss_alarm));
  c_lock: cover property ($rose(hyperframe_number_locked));
  c_withdraw: cover property ($rose(service_withdraw));
endmodule // lam_top_chk

bind lam_top lam_top_chk lam_top_chk_inst
(
  .ref_clk, .rst, .transceiver_error, .startup_at_c, .radio_unit,
  .access_point_defect_request, .tx_alarm_byte, .near_alarms,
  .far_alarms, .hyperframe_number_locked, .resync_to_state_b,
  .emission_block, .service_withdraw, .frame_numbers_invalid
);

// ===== tb/tb.sv
// self-checking bench for the link alarm block with a reference model
// assumes the peer model and the checker are compiled before it
`include "lam_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  lam_pkg::lam_rx_word_t rx_word;
  logic optical_power_low = 1'b0;
  logic transceiver_error = 1'b0;
  logic startup_at_c = 1'b0;
  logic radio_unit = 1'b0;
  logic [3:0] local_max_version = 4'h2;
  logic [3:0] far_version = 4'h2;
  logic access_point_defect_request = 1'b0;
  lam_pkg::lam_filter_cfg_t filter_cfg = '0;
  logic [7:0] tx_alarm_byte, peer_idx, alarm_byte = 8'h00;
  lam_pkg::lam_alarm_t near_alarms, far_alarms;
  logic hyperframe_number_locked, resync_to_state_b, emission_block;
  logic service_withdraw, frame_numbers_invalid;
  logic send = 1'b0, send_comma = 1'b1, descr_ok = 1'b1;
  logic [7:0] viol_words = 8'h00;
  logic m_los = 1'b0, m_lof = 1'b1, m_sap = 1'b0, m_te = 1'b0;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  int viols[4] = '{15, 15, 16, 0};

  lam_top lam_top_inst (.ref_clk, .rst, .rx_word, .optical_power_low,
    .transceiver_error, .startup_at_c, .radio_unit, .local_max_version,
    .far_version, .access_point_defect_request, .filter_cfg,
    .tx_alarm_byte, .near_alarms, .hyperframe_number_locked, .far_alarms,
    .resync_to_state_b, .emission_block, .service_withdraw,
    .frame_numbers_invalid);
  lam_peer lam_peer_inst (.ref_clk, .rst, .send, .send_comma, .descr_ok,
    .viol_words, .alarm_byte, .rx_word, .idx(peer_idx));

  // clock and run limit
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // wait n hyperframe starts, then let filters settle
  task automatic hf(int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      while (peer_idx != 8'h00)
        @(negedge ref_clk);
    end
    repeat (12) @(negedge ref_clk);
  endtask

  // compare every output with the reference model
  task automatic chk_all();
    logic [3:0] far;
    logic rs;
    far = startup_at_c ? alarm_byte[4:1] : 4'h0;
    rs = m_los | m_lof | far[3] | far[2] | far[0];
    check("tx", tx_alarm_byte, {3'h0, m_lof, m_los, m_sap,
      m_lof | m_los | m_te, 1'b0});
    check("near", near_alarms, {m_lof, m_los, m_sap,
      m_lof | m_los | m_te});
    check("far", far_alarms, far);
    check("resync", resync_to_state_b, rs);
    check("emit", emission_block, radio_unit & (rs | far[1]));
    check("withdraw", service_withdraw, far[1]);
    check("invalid", frame_numbers_invalid,
      !radio_unit && far != 0);
    check("lock", hyperframe_number_locked, !m_lof);
  endtask

  // main sequence, inputs move on the falling edge
  initial
  begin
    void'($urandom(7591));
    filter_cfg = {16'($urandom_range(3, 0)), 16'($urandom_range(3, 0)),
      16'($urandom_range(3, 0)), 16'($urandom_range(3, 0))};
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("tx_reset", tx_alarm_byte, 8'h12);
    send = 1'b1;
    hf(3);
    m_lof = 1'b0;
    chk_all();
    foreach (viols[i])
    begin
      viol_words = 8'(viols[i]);
      hf(1);
      m_los = viols[i] >= `LAM_LOS_VIOL_LIMIT;
      chk_all();
    end
    optical_power_low = 1'b1;
    hf(1);
    m_los = 1'b1;
    chk_all();
    optical_power_low = 1'b0;
    hf(2);
    m_los = 1'b0;
    chk_all();
    // random levels, each forced high in one pass
    for (int j = 0; j < 3; j++)
    begin
      m_te = (j == 0) || 1'($urandom_range(1, 0));
      m_sap = (j == 1) || 1'($urandom_range(1, 0));
      transceiver_error = m_te;
      access_point_defect_request = m_sap;
      hf(1);
      chk_all();
    end
    startup_at_c = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      alarm_byte = (k < 4) ? (8'h02 << k) : 8'h00;
      radio_unit = ~radio_unit;
      hf(1);
      chk_all();
    end
    alarm_byte = 8'h1E;
    startup_at_c = 1'b0;
    hf(1);
    chk_all();
    alarm_byte = 8'h00;
    send_comma = 1'b0;
    hf(4);
    m_lof = 1'b1;
    chk_all();
    // commas back but descrambler check failing: no lock
    send_comma = 1'b1;
    descr_ok = 1'b0;
    hf(3);
    chk_all();
    // far end announces version 1: plain procedure locks
    far_version = 4'h1;
    hf(1);
    m_lof = 1'b0;
    chk_all();
    close_out();
  end
endmodule // tb
